// ### verification/gptmr_pin_model.sv
// Behavioural model of the input and output pins at the timer's far side.
`timescale 1ns/10ps
`default_nettype none
module gptmr_pin_model
(
  input  wire logic mclk_in,
  input  wire logic pin_in,
  input  wire logic oe_in,
  output logic      pin_out,
  output logic      line_out
);
  logic last = 1'b0;
  initial pin_out = 1'b0;
  always @(posedge mclk_in) if (oe_in) last <= pin_in;
  // The released pin has no pull, so it shows the inverse of the last driven level.
  assign line_out = oe_in ? pin_in : ~last;
  // Phases of three and three cycles keep each level well above two clocks.
  task pulses(input int n);
    repeat (n)
    begin
      @(posedge mclk_in);
      pin_out <= 1'b1;
      repeat (3) @(posedge mclk_in);
      pin_out <= 1'b0;
      repeat (2) @(posedge mclk_in);
    end
    repeat (3) @(posedge mclk_in);
  endtask : pulses
  task level(input logic v);
    @(posedge mclk_in);
    pin_out <= v;
  endtask : level
endmodule : gptmr_pin_model
`default_nettype wire

// ### verification/testbench.sv
// Self-checking testbench of the timer core.
`timescale 1ns/10ps
`default_nettype none
`include "gptmr_defines.svh"
module testbench;
  import gptmr_pkg::*;
  logic        mclk_in = 0, rst_in = 1, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = 0;
  logic [31:0] pwdata = 0, prdata, rdat;
  logic        pready, pslverr, rerr, pin, opin, oe, line, lint, levt, hint, hevt;
  gptmr_mode_e mode;
  int          n_fail = 0, comparisons = 0, cyc = 0, n, h;
  gptmr_core u_dut (.mclk_in(mclk_in), .rst_in(rst_in), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
    .pslverr_out(pslverr), .counter_input_pin_in(pin), .counter_output_pin_out(opin),
    .counter_output_pin_oe_out(oe), .low_match_interrupt_out(lint), .low_match_dma_event_out(levt),
    .high_match_interrupt_out(hint), .high_match_dma_event_out(hevt), .operating_mode_select_out(mode));
  gptmr_pin_model u_pin (.mclk_in(mclk_in), .pin_in(opin), .oe_in(oe), .pin_out(pin), .line_out(line));
  always #2 mclk_in = ~mclk_in;
  ////////////////////////////////////////////////////////////////////////////
  task summarize;
    $display("Counts: %0d comparisons, %0d mismatches", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : summarize
  always @(posedge mclk_in)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      n_fail++;
      summarize();
    end
  end
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_in);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge mclk_in);
    penable <= 1'b1;
    do @(posedge mclk_in); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    {psel, penable} <= 2'b00;
    // Let the write settle so that callers see the new register state.
    @(negedge mclk_in);
  endtask : bus
  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Cycles until the next match pulse; 100 means none came.
  task wint(input logic hi, output int k);
    k = 0;
    do
    begin
      @(posedge mclk_in);
      k++;
    end while (((hi ? hint : lint) !== 1'b1) && k < 100);
    if (k < 100)
      chk(hi ? hevt : levt, 1);
  endtask : wint
  task highs(input int k, output int c);
    c = 0;
    repeat (k)
    begin
      @(posedge mclk_in);
      c += (line === 1'b1);
    end
  endtask : highs
  ////////////////////////////////////////////////////////////////////////////
  task t_reset;
    chk(mode, GPTMR_MODE_64);
    bus(0, `GPTMR_OFF_CTRL, 0);
    chk(rdat, `GPTMR_CTRL_RST);
    bus(0, `GPTMR_OFF_GCTRL, 0);
    chk(rdat, `GPTMR_GCTRL_RST);
    chk(oe, 0);
    bus(0, 8'h18, 0);
    chk(rerr, 1);
    chk(rdat, 0);
    $display("test reset done");
  endtask : t_reset
  task t_lower;
    bus(1, `GPTMR_OFF_GCTRL, 32'h5);
    chk(mode, GPTMR_MODE_INDEP);
    bus(1, `GPTMR_OFF_PRD_LO, 4);
    bus(1, `GPTMR_OFF_CNT_LO, 0);
    for (int i = 0; i < 8; i++)
    begin
      bus(1, `GPTMR_OFF_CTRL, 32'h80 | (i[1:0] << 4) | (i[2] << 1));
      wint(0, n);
      wint(0, n);
      chk(n, 5);
      highs(5, h);
      chk(h, i[2] ? 4 - i[1:0] : i[1:0] + 1);
    end
    chk(oe, 1);
    bus(1, `GPTMR_OFF_CTRL, 32'h88);
    wint(0, n);
    wint(0, n);
    highs(10, h);
    chk(h, 5);
    bus(1, `GPTMR_OFF_GCTRL, 32'h4);
    chk(oe, 0);
    // The status bit is a registered copy of the shaper output, so give it one more cycle.
    @(posedge mclk_in);
    bus(0, `GPTMR_OFF_CTRL, 0);
    chk(rdat[0], 0);
    bus(1, `GPTMR_OFF_CTRL, 0);
    bus(1, `GPTMR_OFF_GCTRL, 32'h5);
    bus(1, `GPTMR_OFF_CTRL, 32'h40);
    wint(0, n);
    bus(0, `GPTMR_OFF_CNT_LO, 0);
    chk(rdat, 0);
    bus(0, `GPTMR_OFF_CTRL, 0);
    chk(rdat[7:6], 0);
    wint(0, n);
    chk(n, 100);
    $display("test lower done");
  endtask : t_lower
  task t_input;
    bus(1, `GPTMR_OFF_PRD_LO, 32'hff);
    bus(1, `GPTMR_OFF_CTRL, 32'h180);
    u_pin.pulses(5);
    bus(0, `GPTMR_OFF_CNT_LO, 0);
    chk(rdat, 5);
    bus(1, `GPTMR_OFF_CTRL, 32'h500);
    bus(1, `GPTMR_OFF_CNT_LO, 0);
    bus(1, `GPTMR_OFF_CTRL, 32'h580);
    u_pin.pulses(3);
    bus(0, `GPTMR_OFF_CNT_LO, 0);
    chk(rdat, 3);
    bus(1, `GPTMR_OFF_CTRL, 32'h200);
    bus(1, `GPTMR_OFF_CNT_LO, 0);
    bus(1, `GPTMR_OFF_CTRL, 32'h280);
    u_pin.level(1);
    repeat (20) @(posedge mclk_in);
    u_pin.level(0);
    repeat (6) @(posedge mclk_in);
    bus(0, `GPTMR_OFF_CNT_LO, 0);
    chk(rdat >= 19 && rdat <= 21, 1);
    $display("test input done");
  endtask : t_input
  task t_upper;
    bus(1, `GPTMR_OFF_CTRL, 0);
    bus(1, `GPTMR_OFF_GCTRL, 32'h1007);
    bus(1, `GPTMR_OFF_PRD_HI, 1);
    bus(1, `GPTMR_OFF_CNT_HI, 0);
    bus(1, `GPTMR_OFF_CTRL, 32'h800100);
    wint(1, n);
    wint(1, n);
    chk(n, 4);
    bus(1, `GPTMR_OFF_PRD_LO, 0);
    bus(1, `GPTMR_OFF_CNT_LO, 0);
    bus(1, `GPTMR_OFF_CTRL, 32'h80);
    repeat (8) @(posedge mclk_in);
    bus(0, `GPTMR_OFF_CNT_LO, 0);
    chk(rdat, 0);
    bus(1, `GPTMR_OFF_CTRL, 0);
    bus(1, `GPTMR_OFF_GCTRL, 32'h1);
    bus(1, `GPTMR_OFF_PRD_HI, 0);
    bus(1, `GPTMR_OFF_CNT_HI, 0);
    bus(1, `GPTMR_OFF_PRD_LO, 3);
    bus(1, `GPTMR_OFF_CNT_LO, 0);
    bus(1, `GPTMR_OFF_CTRL, 32'h80);
    wint(0, n);
    chk(n, 100);
    bus(1, `GPTMR_OFF_CTRL, 32'h800000);
    bus(1, `GPTMR_OFF_GCTRL, 32'h3);
    wint(0, n);
    chk(n, 100);
    bus(1, `GPTMR_OFF_CTRL, 32'h80);
    wint(0, n);
    wint(0, n);
    chk(n, 4);
    bus(1, `GPTMR_OFF_CTRL, 0);
    bus(1, `GPTMR_OFF_GCTRL, 32'hf);
    chk(mode, GPTMR_MODE_CHAIN);
    bus(1, `GPTMR_OFF_PRD_HI, 2);
    bus(1, `GPTMR_OFF_CNT_HI, 0);
    bus(1, `GPTMR_OFF_PRD_LO, 1);
    bus(1, `GPTMR_OFF_CNT_LO, 0);
    bus(1, `GPTMR_OFF_CTRL, 32'h80);
    wint(0, n);
    wint(0, n);
    chk(n, 6);
    bus(1, `GPTMR_OFF_GCTRL, 32'hb);
    chk(mode, GPTMR_MODE_WDOG);
    wint(0, n);
    chk(n, 100);
    $display("test upper done");
  endtask : t_upper
  initial
  begin
    repeat (12) @(posedge mclk_in);
    rst_in <= 1'b0;
    t_reset();
    t_lower();
    t_input();
    t_upper();
    summarize();
  end
endmodule : testbench
`default_nettype wire

// ### verilog/gptmr_core.sv
// General-purpose timer core: APB registers, 64/chained/independent counting, clock select, outputs.
//
// Contract
// - Two-bit mode selector: 00 64-bit, 01 independent, 10 watchdog, 11 chained; resets 00.
// - 64-bit mode joins high:low words; chained uses high pair as prescaler.
// - Independent upper counter uses 4-bit prescale count/period plus high words.
// - 64-bit or chained counting needs both release bits and low enable 01b/10b.
// - Independent lower counter needs low release bit and low enable 01b/10b.
// - Independent upper counter needs high release bit and enable bits 23:22 01b/10b.
// - Enable field 00 disables, resets to 00; high field ignored outside independent.
// - Lower clock: internal, internal gated by pin, or external pin clock.
// - External input is synchronised and optionally inverted first; invert applies only with the external pin clock, not gated.
// - Upper counter and its prescaler always use the internal clock.
// - Lower clock source resets to ungated internal clock.
// - Gated clock counts from input rising edge until falling edge.
// - Pulse mode: each match gives a pulse of 1 to 4 clocks of the lower clock source, or of mclk_in for the upper half.
// - Pulse mode output inverts when the output-invert bit is 1.
// - Clock mode: output toggles on each match, 50% duty square wave.
// - Lower output drives status bit and pin; upper drives only its status bit.
// - Enabled counter increments once per timer clock until it equals the period.
// - One-shot: on match clear counter to zero, then halt; upper half keeps running if its match coincides with a lower one-shot match.
// - Continuous: on match clear counter to zero and keep counting.
// - External-clocked count value stays coherent in the internal clock domain.
// - Count and period both zero: may be enabled but count does not advance.
// - Each match raises an interrupt and DMA event for that half.
// - One cycle after prescale match, one tick goes out and prescale count clears.
// - Low release cleared: low status cleared, pin high impedance; high likewise status.
//
// Added by the designer: register access over APB and the register addresses.
`timescale 1ns/10ps
`default_nettype none
`include "gptmr_defines.svh"
module gptmr_core
(
  input  wire logic                         mclk_in,
  input  wire logic                         rst_in,
  input  wire logic                         psel_in,
  input  wire logic                         penable_in,
  input  wire logic                         pwrite_in,
  input  wire logic [`GPTMR_ADDR_W-1:0]     paddr_in,
  input  wire logic [31:0]                  pwdata_in,
  output logic      [31:0]                  prdata_out,
  output logic                              pready_out,
  output logic                              pslverr_out,
  input  wire logic                         counter_input_pin_in,
  output logic                              counter_output_pin_out,
  output logic                              counter_output_pin_oe_out,
  output logic                              low_match_interrupt_out,
  output logic                              low_match_dma_event_out,
  output logic                              high_match_interrupt_out,
  output logic                              high_match_dma_event_out,
  output gptmr_pkg::gptmr_mode_e            operating_mode_select_out
);
  import gptmr_pkg::*;

  logic [31:0] count_low_word;
  logic [31:0] count_high_word;
  logic [31:0] period_low_word;
  logic [31:0] period_high_word;
  logic [31:0] counter_control_reg;
  logic [31:0] global_control_reg;
  logic        pin_meta;
  logic        pin_sync;
  logic        pin_prev;
  logic        pre_tick;
  logic        psc_tick;
  logic        low_output_status;
  logic        high_output_status;

  gptmr_mode_e operating_mode_select;
  gptmr_ena_e  low_enable_mode;
  gptmr_ena_e  high_enable_mode;
  logic        low_half_reset_release;
  logic        high_half_reset_release;
  logic [3:0]  high_prescale_count;
  logic [3:0]  high_prescale_period;
  logic        pin_level;
  logic        src_tick;
  logic        ena_lo_ok;
  logic        ena_hi_ok;
  logic        run_lo;
  logic        run_hi;
  logic        step_lo;
  logic        step_hi;
  logic        match_lo;
  logic        match_hi;
  logic        wr_en;
  logic        rd_setup;
  logic        addr_ok;
  logic        wr_cnt_lo;
  logic        wr_cnt_hi;
  logic        wr_ctrl;
  logic        wr_gctrl;
  logic [63:0] count_64;
  logic [63:0] next_count_64;

  ////////////////////////////////////////////////////////////////////////////
  assign operating_mode_select   = gptmr_mode_e'(global_control_reg[`GPTMR_GCTRL_MODE]);
  assign low_enable_mode         = gptmr_ena_e'(counter_control_reg[`GPTMR_CTRL_ENA_LO]);
  assign high_enable_mode        = gptmr_ena_e'(counter_control_reg[`GPTMR_CTRL_ENA_HI]);
  assign low_half_reset_release  = global_control_reg[`GPTMR_GCTRL_LORS];
  assign high_half_reset_release = global_control_reg[`GPTMR_GCTRL_HIRS];
  assign high_prescale_count     = global_control_reg[`GPTMR_GCTRL_PSC];
  assign high_prescale_period    = global_control_reg[`GPTMR_GCTRL_PRD4];
  assign operating_mode_select_out = operating_mode_select;

  assign addr_ok   = paddr_in inside {`GPTMR_OFF_CNT_LO, `GPTMR_OFF_CNT_HI, `GPTMR_OFF_PRD_LO,
                                      `GPTMR_OFF_PRD_HI, `GPTMR_OFF_CTRL, `GPTMR_OFF_GCTRL};
  assign wr_en     = psel_in && penable_in && pwrite_in && addr_ok;
  assign rd_setup  = psel_in && !penable_in && !pwrite_in;
  assign wr_cnt_lo = wr_en && paddr_in == `GPTMR_OFF_CNT_LO;
  assign wr_cnt_hi = wr_en && paddr_in == `GPTMR_OFF_CNT_HI;
  assign wr_ctrl   = wr_en && paddr_in == `GPTMR_OFF_CTRL;
  assign wr_gctrl  = wr_en && paddr_in == `GPTMR_OFF_GCTRL;

  // Zero-wait slave; an unmapped address answers with an error and no effect.
  assign pready_out  = 1'b1;
  assign pslverr_out = psel_in && penable_in && !addr_ok;

  ////////////////////////////////////////////////////////////////////////////
  // Read data is latched in the setup phase so it stands through the access phase.
  always_ff @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
      prdata_out <= 32'h00000000;
    else if (rd_setup)
    begin
      unique case (paddr_in)
        `GPTMR_OFF_CNT_LO: prdata_out <= count_low_word;
        `GPTMR_OFF_CNT_HI: prdata_out <= count_high_word;
        `GPTMR_OFF_PRD_LO: prdata_out <= period_low_word;
        `GPTMR_OFF_PRD_HI: prdata_out <= period_high_word;
        `GPTMR_OFF_CTRL:   prdata_out <= counter_control_reg;
        `GPTMR_OFF_GCTRL:  prdata_out <= global_control_reg;
        default:           prdata_out <= 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      period_low_word  <= 32'h00000000;
      period_high_word <= 32'h00000000;
    end
    else if (wr_en && paddr_in == `GPTMR_OFF_PRD_LO)
      period_low_word <= pwdata_in;
    else if (wr_en && paddr_in == `GPTMR_OFF_PRD_HI)
      period_high_word <= pwdata_in;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status bits are registered copies of the output shapers and are not writable.
  always_ff @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
      counter_control_reg <= `GPTMR_CTRL_RST;
    else
    begin
      if (wr_ctrl)
        counter_control_reg <= (pwdata_in & `GPTMR_CTRL_WMASK) | (counter_control_reg & ~`GPTMR_CTRL_WMASK);
      else if (match_lo && low_enable_mode == GPTMR_ENA_ONCE)
        counter_control_reg[`GPTMR_CTRL_ENA_LO] <= GPTMR_ENA_OFF;
      else if (match_hi && high_enable_mode == GPTMR_ENA_ONCE)
        counter_control_reg[`GPTMR_CTRL_ENA_HI] <= GPTMR_ENA_OFF;
      counter_control_reg[`GPTMR_CTRL_STAT_LO] <= low_output_status;
      counter_control_reg[`GPTMR_CTRL_STAT_HI] <= high_output_status;
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
      global_control_reg <= `GPTMR_GCTRL_RST;
    else if (wr_gctrl)
      global_control_reg <= pwdata_in & `GPTMR_GCTRL_WMASK;
    else if (run_hi)
      global_control_reg[`GPTMR_GCTRL_PSC] <= (high_prescale_count == high_prescale_period) ? 4'h0
                                              : high_prescale_count + 4'h1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // The pin is asynchronous to mclk_in; only pin_sync is looked at.
  always_ff @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      pin_meta <= 1'b0;
      pin_sync <= 1'b0;
      pin_prev <= 1'b0;
    end
    else
    begin
      pin_meta <= counter_input_pin_in;
      pin_sync <= pin_meta;
      pin_prev <= pin_level;
    end
  end

  assign pin_level = pin_sync ^ (counter_control_reg[`GPTMR_CTRL_LOW_CLOCK_SOURCE]
                                 & counter_control_reg[`GPTMR_CTRL_LOW_INPUT_INVERT]);

  always_comb
  begin
    if (counter_control_reg[`GPTMR_CTRL_LOW_CLOCK_SOURCE])
      src_tick = pin_level && !pin_prev;
    else if (counter_control_reg[`GPTMR_CTRL_GATE_LO])
      src_tick = pin_sync;
    else
      src_tick = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  assign ena_lo_ok = low_enable_mode inside {GPTMR_ENA_ONCE, GPTMR_ENA_CONT};
  assign ena_hi_ok = high_enable_mode inside {GPTMR_ENA_ONCE, GPTMR_ENA_CONT};

  always_comb
  begin
    unique case (operating_mode_select)
      GPTMR_MODE_64, GPTMR_MODE_CHAIN:
      begin
        run_lo = low_half_reset_release && high_half_reset_release && ena_lo_ok;
        run_hi = 1'b0;
      end
      GPTMR_MODE_INDEP:
      begin
        run_lo = low_half_reset_release && ena_lo_ok;
        run_hi = high_half_reset_release && ena_hi_ok;
      end
      GPTMR_MODE_WDOG:
      begin
        run_lo = 1'b0;
        run_hi = 1'b0;
      end
    endcase
  end

  assign count_64 = {count_high_word, count_low_word};
  assign step_lo  = run_lo && (operating_mode_select == GPTMR_MODE_CHAIN ? pre_tick : src_tick);
  assign step_hi  = run_hi && psc_tick;
  assign match_lo = step_lo && (operating_mode_select == GPTMR_MODE_64 ? count_64 == {period_high_word, period_low_word}
                                                                     : count_low_word == period_low_word);
  assign match_hi = step_hi && count_high_word == period_high_word;
  assign next_count_64 = match_lo ? 64'h0 : count_64 + 64'h1;

  // Prescaler ticks are registered, so the following counter steps one cycle after the match.
  always_ff @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      pre_tick <= 1'b0;
      psc_tick <= 1'b0;
    end
    else
    begin
      pre_tick <= run_lo && operating_mode_select == GPTMR_MODE_CHAIN
                  && count_high_word == period_high_word;
      psc_tick <= run_hi && high_prescale_count == high_prescale_period;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // A software write to a count word wins over the counting in the same cycle.
  always_ff @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
      count_low_word <= 32'h00000000;
    else if (wr_cnt_lo)
      count_low_word <= pwdata_in;
    else if (step_lo)
      count_low_word <= next_count_64[31:0];
  end

  always_ff @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
      count_high_word <= 32'h00000000;
    else if (wr_cnt_hi)
      count_high_word <= pwdata_in;
    else if (operating_mode_select == GPTMR_MODE_64 && step_lo)
      count_high_word <= next_count_64[63:32];
    else if (operating_mode_select == GPTMR_MODE_CHAIN && run_lo)
      count_high_word <= (count_high_word == period_high_word) ? 32'h00000000 : count_high_word + 32'h1;
    else if (step_hi)
      count_high_word <= match_hi ? 32'h00000000 : count_high_word + 32'h1;
  end

  always_ff @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      low_match_interrupt_out  <= 1'b0;
      low_match_dma_event_out  <= 1'b0;
      high_match_interrupt_out <= 1'b0;
      high_match_dma_event_out <= 1'b0;
    end
    else
    begin
      low_match_interrupt_out  <= match_lo;
      low_match_dma_event_out  <= match_lo;
      high_match_interrupt_out <= match_hi;
      high_match_dma_event_out <= match_hi;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  gptmr_outgen u_out_lo
  (
    .mclk_in       (mclk_in),
    .rst_in        (rst_in),
    .release_in    (low_half_reset_release),
    .tick_in       (src_tick),
    .match_in      (match_lo),
    .clock_mode_in (counter_control_reg[`GPTMR_CTRL_LOW_CLOCK_PULSE_SELECT]),
    .width_in      (counter_control_reg[`GPTMR_CTRL_LOW_PULSE_WIDTH]),
    .invert_in     (counter_control_reg[`GPTMR_CTRL_INVOUT_LO]),
    .status_out    (low_output_status)
  );

  gptmr_outgen u_out_hi
  (
    .mclk_in       (mclk_in),
    .rst_in        (rst_in),
    .release_in    (high_half_reset_release),
    .tick_in       (1'b1),
    .match_in      (match_hi),
    .clock_mode_in (counter_control_reg[`GPTMR_CTRL_HIGH_CLOCK_PULSE_SELECT]),
    .width_in      (counter_control_reg[`GPTMR_CTRL_HIGH_PULSE_WIDTH]),
    .invert_in     (counter_control_reg[`GPTMR_CTRL_INVOUT_HI]),
    .status_out    (high_output_status)
  );

  // Only the lower half reaches the pin; it floats while the lower half is held.
  assign counter_output_pin_out    = low_output_status;
  assign counter_output_pin_oe_out = low_half_reset_release;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in);

  pin_release_a: assert property (!low_half_reset_release
    |-> !counter_output_pin_oe_out ##1 !low_output_status)
    else $error("Low output not cleared while its half is held.");
  oneshot_halt_a: assert property (match_lo && low_enable_mode == GPTMR_ENA_ONCE && !wr_ctrl
    |=> low_enable_mode == GPTMR_ENA_OFF && !run_lo)
    else $error("One-shot counter kept running after its match.");
  cont_wrap_a: assert property (match_lo && low_enable_mode == GPTMR_ENA_CONT && !wr_en
    |=> count_low_word == 32'h0 && low_enable_mode == GPTMR_ENA_CONT)
    else $error("Continuous counter did not wrap to zero.");
  count_step_a: assert property (operating_mode_select == GPTMR_MODE_INDEP && step_lo && !match_lo && !wr_en
    |=> count_low_word == $past(count_low_word) + 32'h1)
    else $error("Lower counter did not step by one.");
  zero_hold_a: assert property (operating_mode_select == GPTMR_MODE_INDEP && count_low_word == 32'h0
    && period_low_word == 32'h0 && !wr_en |=> count_low_word == 32'h0)
    else $error("Zero count advanced with zero period.");
  hi_ignored_a: assert property (operating_mode_select != GPTMR_MODE_INDEP |-> !step_hi ##1 !psc_tick)
    else $error("High enable field acted outside independent mode.");
  presc_tick_a: assert property (operating_mode_select == GPTMR_MODE_CHAIN && run_lo && !wr_en
    && count_high_word == period_high_word |=> pre_tick && count_high_word == 32'h0)
    else $error("Prescaler did not tick and clear after its match.");
  ext_edge_a: assert property (counter_control_reg[`GPTMR_CTRL_LOW_CLOCK_SOURCE] && src_tick
    |-> !pin_prev ##1 !src_tick)
    else $error("External edge gave more than one count enable.");
  match_event_a: assert property (match_lo |=> low_match_interrupt_out && low_match_dma_event_out)
    else $error("Match did not raise interrupt and event.");
  low_enable_a: assert property (operating_mode_select == GPTMR_MODE_64 && !high_half_reset_release
    |-> !run_lo)
    else $error("64-bit counter ran without the high release bit.");

  oneshot_c: cover property (match_lo && low_enable_mode == GPTMR_ENA_ONCE);
  chain_c:   cover property (operating_mode_select == GPTMR_MODE_CHAIN && match_lo);
  indep_c:   cover property (operating_mode_select == GPTMR_MODE_INDEP && match_hi ##[1:50] match_lo);
  ext_c:     cover property (counter_control_reg[`GPTMR_CTRL_LOW_CLOCK_SOURCE] && step_lo);
endmodule : gptmr_core
`default_nettype wire

// ### verilog/gptmr_defines.svh
// Register offsets, field positions and reset values of the general-purpose timer.
`ifndef GPTMR_DEFINES_SVH
`define GPTMR_DEFINES_SVH

`define GPTMR_ADDR_W          8
`define GPTMR_OFF_CNT_LO      8'h00
`define GPTMR_OFF_CNT_HI      8'h04
`define GPTMR_OFF_PRD_LO      8'h08
`define GPTMR_OFF_PRD_HI      8'h0c
`define GPTMR_OFF_CTRL        8'h10
`define GPTMR_OFF_GCTRL       8'h14

`define GPTMR_CTRL_STAT_LO    0
`define GPTMR_CTRL_INVOUT_LO  1
`define GPTMR_CTRL_LOW_CLOCK_PULSE_SELECT      3
`define GPTMR_CTRL_LOW_PULSE_WIDTH    5:4
`define GPTMR_CTRL_ENA_LO     7:6
`define GPTMR_CTRL_LOW_CLOCK_SOURCE  8
`define GPTMR_CTRL_GATE_LO    9
`define GPTMR_CTRL_LOW_INPUT_INVERT  10
`define GPTMR_CTRL_STAT_HI    16
`define GPTMR_CTRL_INVOUT_HI  17
`define GPTMR_CTRL_HIGH_CLOCK_PULSE_SELECT      19
`define GPTMR_CTRL_HIGH_PULSE_WIDTH    21:20
`define GPTMR_CTRL_ENA_HI     23:22
`define GPTMR_CTRL_WMASK      32'h00fa07fa
`define GPTMR_CTRL_RST        32'h00000000

`define GPTMR_GCTRL_LORS      0
`define GPTMR_GCTRL_HIRS      1
`define GPTMR_GCTRL_MODE      3:2
`define GPTMR_GCTRL_PSC       11:8
`define GPTMR_GCTRL_PRD4      15:12
`define GPTMR_GCTRL_WMASK     32'h0000ff0f
`define GPTMR_GCTRL_RST       32'h00000000

`endif

// ### verilog/gptmr_outgen.sv
// Output shaper of one timer half: pulse or square-wave status level.
`timescale 1ns/10ps
`default_nettype none
module gptmr_outgen
(
  input  wire logic       mclk_in,
  input  wire logic       rst_in,
  input  wire logic       release_in,
  input  wire logic       tick_in,
  input  wire logic       match_in,
  input  wire logic       clock_mode_in,
  input  wire logic [1:0] width_in,
  input  wire logic       invert_in,
  output logic            status_out
);
  import gptmr_pkg::*;

  logic       toggle;
  logic       pulse;
  logic [1:0] remain;

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      toggle <= 1'b0;
      pulse  <= 1'b0;
      remain <= 2'h0;
    end
    else if (!release_in)
    begin
      toggle <= 1'b0;
      pulse  <= 1'b0;
      remain <= 2'h0;
    end
    else if (match_in)
    begin
      // The match cycle itself is the first pulse clock, so only the extra clocks are held here.
      toggle <= ~toggle;
      pulse  <= (width_in != 2'h0);
      remain <= width_in;
    end
    else if (tick_in && pulse)
    begin
      // Width counts tick_in, so a slow lower clock source stretches the lower pulse; the upper half counts every mclk_in.
      if (remain == 2'h1)
        pulse <= 1'b0;
      remain <= remain - 2'h1;
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
      status_out <= 1'b0;
    else if (!release_in)
      status_out <= 1'b0;
    else if (clock_mode_in)
      status_out <= match_in ? ~toggle : toggle;
    else
      status_out <= (match_in | pulse) ^ invert_in;
  end

  ////////////////////////////////////////////////////////////////////////////
  pulse_start_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    match_in && release_in && !clock_mode_in
    |=> pulse == ($past(width_in) != 2'h0) && status_out == !$past(invert_in))
    else $error("Pulse did not start on a period match.");
endmodule : gptmr_outgen
`default_nettype wire

// ### verilog/gptmr_pkg.sv
// Types shared by the general-purpose timer modules.
package gptmr_pkg;
  typedef enum logic [1:0]
  {
    GPTMR_MODE_64    = 2'b00,
    GPTMR_MODE_INDEP = 2'b01,
    GPTMR_MODE_WDOG  = 2'b10,
    GPTMR_MODE_CHAIN = 2'b11
  } gptmr_mode_e;

  typedef enum logic [1:0]
  {
    GPTMR_ENA_OFF    = 2'b00,
    GPTMR_ENA_ONCE   = 2'b01,
    GPTMR_ENA_CONT   = 2'b10,
    GPTMR_ENA_RSVD   = 2'b11
  } gptmr_ena_e;
endpackage : gptmr_pkg
